// ==== pkg/metering_consts.svh ====
`ifndef METERING_CONSTS_SVH
`define METERING_CONSTS_SVH
`define ADDR_POWER_GAIN    5'h0b
`define ADDR_PHASE         5'h0c
`define ADDR_POWER_OFFSET  5'h0d
`define ADDR_ZX_TIMEOUT    5'h0e
`define ADDR_DIP_CYCLES    5'h0f
`define ADDR_IRQ_MASK      5'h10
`define ADDR_DIP_LEVEL     5'h11
`define ADDR_TEMPERATURE   5'h12
`define ADDR_HALF_CYCLES   5'h13
`define ADDR_CYCLE_ENERGY  5'h14
`define ADDR_PULSE_NUM     5'h15
`define ADDR_ONES_COUNT    5'h1e
`define ADDR_REVISION      5'h1f
`define RST_ZX_TIMEOUT     12'hfff
`define RST_DIP_CYCLES     8'hff
`define RST_IRQ_MASK       8'h40
`define RST_HALF_CYCLES    14'h3fff
`define CMD_BITS           6'h08
`define XFER_ONE_BYTE      6'h08
`define XFER_TWO_BYTES     6'h10
`define XFER_FIVE_BYTES    6'h28
`define MAX_XFER_BITS      6'h28
`define GAIN_FRAC_BITS     12
`define PHASE_MIN          8'h9e
`define PHASE_MAX          8'h5c
`define IRQ_CYCLE_DONE     2
`define IRQ_DIP            3
`define IRQ_ZX_TIMEOUT     4
`define REF_CLK_MHZ        250
`define ZX_TIMEOUT_MAX_US  150000
`define ZX_TIMEOUT_STEPS   4095
`endif

// ==== pkg/metering_pkg.sv ====
package metering_pkg;
   typedef logic signed [23:0] power_t;
   typedef struct packed {
      logic       write;
      logic [1:0] unused;
      logic [4:0] addr;
   } cmd_t;
   typedef struct packed {
      logic [11:0] gain;
      logic [7:0]  phase;
      logic [15:0] offset;
      logic [11:0] zx_timeout;
      logic [7:0]  dip_cycles;
      logic [7:0]  irq_mask;
      logic [7:0]  dip_level;
      logic [13:0] half_cycles;
      logic [11:0] pulse_num;
   } cfg_t;
   typedef struct packed {
      cfg_t        cfg;
      logic [7:0]  temperature;
      logic [39:0] cycle_energy;
   } snap_t;
endpackage : metering_pkg

// ==== verilog/metering_calib_register_bank.sv ====
`timescale 1ns/1ns
`include "metering_consts.svh"

//
// Contract
// R1 - active power is scaled by a signed 12-bit gain trim, 1/4096 per step
// R2 - phase trim is two's complement, clamped to the range 9Eh to 5Ch
// R3 - a signed 16-bit offset is added to the active power result
// R4 - missing channel 2 zero crossing within the timeout raises the interrupt
// R5 - dip output asserts after the programmed count of low half cycles
// R6 - channel 2 peak is compared against the 8-bit dip threshold
// R7 - masked events still set status but do not drive the interrupt
// R8 - the latest temperature conversion is held in a read-only register
// R9 - line cycle mode accumulates over the 14-bit half cycle count
// R10 - line cycle energy lands in a separate 40-bit read-only register
// R11 - the 12-bit numerator scales the energy pulse divider
// R12 - a 6-bit register counts the ones sent in the previous read
// R13 - a read-only register holds the silicon revision
// R14 - host sends the command byte before any register data
// R15 - the write-only command byte selects direction and target register
// R16 - command bit 7 high means write, low means read
// R17 - command bits 4 to 0 address the register, bits 6 and 5 unused
// R18 - writes to read-only registers are ignored
module metering_calib_register_bank #(
   parameter int         ZX_TICK_CYCLES = `ZX_TIMEOUT_MAX_US * `REF_CLK_MHZ / `ZX_TIMEOUT_STEPS,
   parameter int         PULSE_SHIFT    = 8,
   parameter logic [7:0] SILICON_REV    = 8'ha5   // arbitrary value
) (
   input  wire logic                ref_clk_i,
   input  wire logic                reset_n_i,
   input  wire logic                sclk_i,
   input  wire logic                cs_n_i,
   input  wire logic                din_i,
   output logic                     dout_o,
   output logic                     dout_oe_o,
   input  wire metering_pkg::power_t raw_power_i,
   input  wire logic                power_valid_i,
   input  wire logic                ch2_zero_cross_i,
   input  wire logic [7:0]          ch2_peak_i,
   input  wire logic [7:0]          temp_value_i,
   input  wire logic                temp_done_i,
   input  wire logic                cycle_mode_i,
   input  wire logic [11:0]         pulse_den_i,
   input  wire logic [7:0]          status_clear_i,
   output metering_pkg::power_t     corrected_power_o,
   output logic [7:0]               phase_shift_o,
   output logic                     energy_pulse_o,
   output logic                     dip_n_o,
   output logic                     irq_n_o,
   output logic [7:0]               status_o
);
   import metering_pkg::*;

   localparam int TICK_W = $clog2(ZX_TICK_CYCLES);

   function automatic logic [5:0] xfer_bits(input logic [4:0] addr);
      case (addr)
         `ADDR_POWER_GAIN, `ADDR_POWER_OFFSET, `ADDR_ZX_TIMEOUT,
         `ADDR_HALF_CYCLES, `ADDR_PULSE_NUM: xfer_bits = `XFER_TWO_BYTES;
         `ADDR_CYCLE_ENERGY:                 xfer_bits = `XFER_FIVE_BYTES;
         default:                            xfer_bits = `XFER_ONE_BYTE;
      endcase
   endfunction : xfer_bits

   // ------------------------------------------------------------------
   // serial side, clocked by the host's sclk
   // ------------------------------------------------------------------
   cmd_t        cmd_q;
   logic        cmd_done_q;
   logic [5:0]  bit_cnt_q;
   logic [39:0] wr_sh_q;
   logic [39:0] wr_data_q;
   logic [4:0]  wr_addr_q;
   logic        wr_tgl_q;
   logic        rd_started_q;
   logic [39:0] rd_sh_q;
   logic [5:0]  ones_q;
   logic        dout_q;
   logic        oe_q;
   snap_t       snap_q;
   logic [39:0] rd_word;
   logic [39:0] rd_aligned;
   logic        data_last;
   logic        rd_first;
   logic        rd_next;

   assign data_last = cmd_done_q && (bit_cnt_q == xfer_bits(cmd_q.addr) - 6'h01);
   assign rd_first  = cmd_done_q && !cmd_q.write && !rd_started_q;
   assign rd_next   = cmd_done_q && !cmd_q.write && rd_started_q;

   // the command byte is shifted in first; data bits only count after it
   always_ff @(negedge sclk_i or posedge cs_n_i or negedge reset_n_i) begin
      if (!reset_n_i || cs_n_i) begin
         cmd_q      <= '0;
         cmd_done_q <= 1'b0;
         bit_cnt_q  <= '0;
         oe_q       <= 1'b0;
      end else if (!cmd_done_q) begin
         cmd_q <= cmd_t'({cmd_q[6:0], din_i});   // R14 R15
         if (bit_cnt_q == `CMD_BITS - 6'h01) begin
            cmd_done_q <= 1'b1;
            bit_cnt_q  <= '0;
            oe_q       <= !cmd_q[6];   // R16
         end else begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
      end else if (data_last) begin
         // back to command mode, so several transfers may share one frame
         cmd_done_q <= 1'b0;
         bit_cnt_q  <= '0;
         oe_q       <= 1'b0;
      end else begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
      end
   end

   // write words are held until the next write, so the toggle handshake is safe
   always_ff @(negedge sclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_sh_q   <= '0;
         wr_data_q <= '0;
         wr_addr_q <= '0;
         wr_tgl_q  <= 1'b0;
      end else if (!cs_n_i && cmd_done_q && cmd_q.write) begin
         wr_sh_q <= {wr_sh_q[38:0], din_i};
         if (data_last) begin
            wr_data_q <= {wr_sh_q[38:0], din_i};
            wr_addr_q <= cmd_q.addr;   // R17
            wr_tgl_q  <= ~wr_tgl_q;
         end
      end
   end

   // snap_q is frozen in the reference domain while the frame is open
   always_comb begin
      rd_word = '0;
      case (cmd_q.addr)   // R17
         `ADDR_POWER_GAIN:   rd_word = 40'(snap_q.cfg.gain);
         `ADDR_PHASE:        rd_word = 40'(snap_q.cfg.phase);
         `ADDR_POWER_OFFSET: rd_word = 40'(snap_q.cfg.offset);
         `ADDR_ZX_TIMEOUT:   rd_word = 40'(snap_q.cfg.zx_timeout);
         `ADDR_DIP_CYCLES:   rd_word = 40'(snap_q.cfg.dip_cycles);
         `ADDR_IRQ_MASK:     rd_word = 40'(snap_q.cfg.irq_mask);
         `ADDR_DIP_LEVEL:    rd_word = 40'(snap_q.cfg.dip_level);
         `ADDR_TEMPERATURE:  rd_word = 40'(snap_q.temperature);
         `ADDR_HALF_CYCLES:  rd_word = 40'(snap_q.cfg.half_cycles);
         `ADDR_CYCLE_ENERGY: rd_word = snap_q.cycle_energy;
         `ADDR_PULSE_NUM:    rd_word = 40'(snap_q.cfg.pulse_num);
         `ADDR_ONES_COUNT:   rd_word = 40'(ones_q);   // R12
         `ADDR_REVISION:     rd_word = 40'(SILICON_REV);   // R13
         default:            rd_word = '0;
      endcase
      rd_aligned = rd_word << (`MAX_XFER_BITS - xfer_bits(cmd_q.addr));
   end

   // whole word captured at the first bit, so a multi-byte read never tears
   always_ff @(posedge sclk_i or posedge cs_n_i or negedge reset_n_i) begin
      if (!reset_n_i || cs_n_i) begin
         rd_started_q <= 1'b0;
         rd_sh_q      <= '0;
         dout_q       <= 1'b0;
      end else if (rd_first) begin
         rd_started_q <= 1'b1;
         dout_q       <= rd_aligned[39];
         rd_sh_q      <= {rd_aligned[38:0], 1'b0};
      end else if (rd_next) begin
         dout_q  <= rd_sh_q[39];
         rd_sh_q <= {rd_sh_q[38:0], 1'b0};
      end else begin
         rd_started_q <= 1'b0;
      end
   end

   // ones counter restarts at the first bit of each read; writes leave it alone
   always_ff @(posedge sclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ones_q <= '0;
      end else if (!cs_n_i && rd_first) begin
         ones_q <= 6'(rd_aligned[39]);   // R12
      end else if (!cs_n_i && rd_next) begin
         ones_q <= ones_q + 6'(rd_sh_q[39]);   // R12
      end
   end

   assign dout_o    = dout_q;
   assign dout_oe_o = oe_q;

   // ------------------------------------------------------------------
   // crossing into the reference clock domain
   // ------------------------------------------------------------------
   logic [2:0] tgl_sync_q;
   logic [1:0] cs_sync_q;
   logic       wr_pulse;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tgl_sync_q <= '0;
         cs_sync_q  <= 2'h3;
      end else begin
         tgl_sync_q <= {tgl_sync_q[1:0], wr_tgl_q};
         cs_sync_q  <= {cs_sync_q[0], cs_n_i};
      end
   end

   assign wr_pulse = tgl_sync_q[2] ^ tgl_sync_q[1];

   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   cfg_t        cfg_q;
   logic [7:0]  temp_q;
   logic [39:0] energy_q;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_q             <= '0;
         cfg_q.zx_timeout  <= `RST_ZX_TIMEOUT;
         cfg_q.dip_cycles  <= `RST_DIP_CYCLES;
         cfg_q.irq_mask    <= `RST_IRQ_MASK;
         cfg_q.half_cycles <= `RST_HALF_CYCLES;
      end else if (wr_pulse) begin
         case (wr_addr_q)   // R15
            `ADDR_POWER_GAIN:   cfg_q.gain        <= wr_data_q[11:0];
            `ADDR_PHASE:        cfg_q.phase       <= wr_data_q[7:0];
            `ADDR_POWER_OFFSET: cfg_q.offset      <= wr_data_q[15:0];
            `ADDR_ZX_TIMEOUT:   cfg_q.zx_timeout  <= wr_data_q[11:0];
            `ADDR_DIP_CYCLES:   cfg_q.dip_cycles  <= wr_data_q[7:0];
            `ADDR_IRQ_MASK:     cfg_q.irq_mask    <= wr_data_q[7:0];
            `ADDR_DIP_LEVEL:    cfg_q.dip_level   <= wr_data_q[7:0];
            `ADDR_HALF_CYCLES:  cfg_q.half_cycles <= wr_data_q[13:0];
            `ADDR_PULSE_NUM:    cfg_q.pulse_num   <= wr_data_q[11:0];
            default:            cfg_q             <= cfg_q;   // R18
         endcase
      end
   end

   // the snapshot follows only between frames; host must keep the
   // command-to-read gap after a write so the write has landed first
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         snap_q <= '0;
      end else if (cs_sync_q[1]) begin
         snap_q <= '{cfg: cfg_q, temperature: temp_q, cycle_energy: energy_q};
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         temp_q <= '0;
      end else if (temp_done_i) begin
         temp_q <= temp_value_i;   // R8
      end
   end

   // ------------------------------------------------------------------
   // calibration of active power
   // ------------------------------------------------------------------
   logic signed [35:0] gain_prod;
   logic signed [25:0] corr_sum;
   power_t             corrected_q;
   logic               corr_valid_q;
   logic [7:0]         phase_q;

   assign gain_prod = raw_power_i * $signed(cfg_q.gain);
   assign corr_sum  = 26'(raw_power_i) + 26'(gain_prod >>> `GAIN_FRAC_BITS)
                    + 26'($signed(cfg_q.offset));

   // wraps rather than saturates; a large sample with positive gain or offset can leave the 24-bit range
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         corrected_q  <= '0;
         corr_valid_q <= 1'b0;
      end else begin
         corr_valid_q <= power_valid_i;
         if (power_valid_i) begin
            corrected_q <= power_t'(corr_sum);   // R1 R3
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase_q <= '0;
      end else if ($signed(cfg_q.phase) < $signed(`PHASE_MIN)) begin
         phase_q <= `PHASE_MIN;   // R2
      end else if ($signed(cfg_q.phase) > $signed(`PHASE_MAX)) begin
         phase_q <= `PHASE_MAX;   // R2
      end else begin
         phase_q <= cfg_q.phase;
      end
   end

   assign corrected_power_o = corrected_q;
   assign phase_shift_o     = phase_q;

   // ------------------------------------------------------------------
   // zero crossing timeout and voltage dip
   // ------------------------------------------------------------------
   logic [TICK_W-1:0] tick_cnt_q;
   logic [11:0]       zx_cnt_q;
   logic              zx_timeout_ev;
   logic [7:0]        dip_cnt_q;
   logic              dip_n_q;
   logic              dip_ev;
   logic              tick;

   assign tick          = tick_cnt_q == TICK_W'(ZX_TICK_CYCLES - 1);
   assign zx_timeout_ev = tick && (zx_cnt_q == '0) && !ch2_zero_cross_i;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tick_cnt_q <= '0;
      end else if (tick || ch2_zero_cross_i) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + TICK_W'(1);
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         zx_cnt_q <= `RST_ZX_TIMEOUT;
      end else if (ch2_zero_cross_i || zx_timeout_ev) begin
         zx_cnt_q <= cfg_q.zx_timeout;   // R4
      end else if (tick) begin
         zx_cnt_q <= zx_cnt_q - 12'h001;
      end
   end

   // one peak sample per half cycle, taken at the zero crossing
   assign dip_ev = ch2_zero_cross_i && (ch2_peak_i < cfg_q.dip_level) && dip_n_q
                 && (dip_cnt_q + 8'h01 >= cfg_q.dip_cycles);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dip_cnt_q <= '0;
         dip_n_q   <= 1'b1;
      end else if (ch2_zero_cross_i) begin
         if (ch2_peak_i < cfg_q.dip_level) begin   // R6
            if (dip_cnt_q != 8'hff) begin
               dip_cnt_q <= dip_cnt_q + 8'h01;
            end
            if (dip_ev) begin
               dip_n_q <= 1'b0;   // R5
            end
         end else begin
            dip_cnt_q <= '0;
            dip_n_q   <= 1'b1;
         end
      end
   end

   assign dip_n_o = dip_n_q;

   // ------------------------------------------------------------------
   // line cycle accumulation and energy pulse
   // ------------------------------------------------------------------
   logic [39:0] line_acc_q;
   logic [39:0] line_next;
   logic [13:0] half_cnt_q;
   logic        cycle_done;
   logic [47:0] pulse_acc_q;
   logic [47:0] pulse_inc;
   logic [47:0] pulse_thr;
   logic        pulse_q;

   assign line_next  = line_acc_q + (corr_valid_q ? 40'(corrected_q) : 40'h0);
   assign cycle_done = cycle_mode_i && ch2_zero_cross_i
                     && (half_cnt_q + 14'h0001 >= cfg_q.half_cycles);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         line_acc_q <= '0;
         half_cnt_q <= '0;
         energy_q   <= '0;
      end else if (!cycle_mode_i) begin
         line_acc_q <= '0;
         half_cnt_q <= '0;
      end else if (cycle_done) begin
         energy_q   <= line_next;   // R9 R10
         line_acc_q <= '0;
         half_cnt_q <= '0;
      end else begin
         line_acc_q <= line_next;   // R10
         if (ch2_zero_cross_i) begin
            half_cnt_q <= half_cnt_q + 14'h0001;   // R9
         end
      end
   end

   // rate = power * (numerator + 1) / ((denominator + 1) << PULSE_SHIFT)
   assign pulse_inc = (corr_valid_q && corrected_q > 0) ?
                      48'($unsigned(corrected_q)) * 48'({1'b0, cfg_q.pulse_num} + 13'h0001) : 48'h0;
   assign pulse_thr = 48'({1'b0, pulse_den_i} + 13'h0001) << PULSE_SHIFT;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pulse_acc_q <= '0;
         pulse_q     <= 1'b0;
      end else if (pulse_acc_q >= pulse_thr) begin
         pulse_acc_q <= pulse_acc_q - pulse_thr + pulse_inc;   // R11
         pulse_q     <= 1'b1;
      end else begin
         pulse_acc_q <= pulse_acc_q + pulse_inc;   // R11
         pulse_q     <= 1'b0;
      end
   end

   assign energy_pulse_o = pulse_q;

   // ------------------------------------------------------------------
   // event flags and interrupt request
   // ------------------------------------------------------------------
   logic [7:0] status_q;
   logic [7:0] status_set;
   logic       irq_n_q;

   always_comb begin
      status_set                  = '0;
      status_set[`IRQ_CYCLE_DONE] = cycle_done;
      status_set[`IRQ_DIP]        = dip_ev;
      status_set[`IRQ_ZX_TIMEOUT] = zx_timeout_ev;
   end

   // a set arriving with its clear wins, so no event is lost
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_q <= '0;
         irq_n_q  <= 1'b1;
      end else begin
         status_q <= status_set | (status_q & ~status_clear_i);   // R7
         irq_n_q  <= ~|(status_q & cfg_q.irq_mask);   // R4 R7
      end
   end

   assign status_o = status_q;
   assign irq_n_o  = irq_n_q;

endmodule : metering_calib_register_bank

// ==== testbench/metering_calib_register_bank_checker.sv ====
`timescale 1ns/1ns
module metering_calib_register_bank_checker (
   input wire logic       ref_clk_i,
   input wire logic       reset_n_i,
   input wire logic       sclk_i,
   input wire logic       cs_n_i,
   input wire logic       din_i,
   input wire logic       dout_oe_o,
   input wire logic       ch2_zero_cross_i,
   input wire logic       cycle_mode_i,
   input wire logic [7:0] status_clear_i,
   input wire logic [7:0] phase_shift_o,
   input wire logic       dip_n_o,
   input wire logic       irq_n_o,
   input wire logic [7:0] status_o
);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   AST_IRQ_IDLE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      status_o == 8'h00 |=> irq_n_o) else $error("irq without status");
   AST_PHASE_RANGE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      $signed(phase_shift_o) >= $signed(8'h9e) && $signed(phase_shift_o) <= $signed(8'h5c))
      else $error("phase out of range");
   AST_DIP_CAUSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      $fell(dip_n_o) |-> $past(ch2_zero_cross_i) || $past(ch2_zero_cross_i, 2))
      else $error("dip without crossing");
   AST_DIP_STATUS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      $fell(dip_n_o) |-> ##[0:1] status_o[3]) else $error("dip without flag");
   AST_CYCLE_DONE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      $rose(status_o[2]) |-> $past(cycle_mode_i)) else $error("cycle done outside mode");
   AST_ZX_STICKY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      $fell(status_o[4]) |-> $past(status_clear_i[4])) else $error("timeout flag lost");
   AST_OE_IDLE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
      cs_n_i && $past(cs_n_i) |-> !dout_oe_o) else $error("dout driven outside frame");
   // bit 7 of the command was sampled eight falls before the enable shows
   AST_OE_READ: assert property (@(negedge sclk_i) disable iff (!reset_n_i)
      $rose(dout_oe_o) |-> !$past(din_i, 8)) else $error("dout driven after write command");
   cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $fell(dip_n_o));
   cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(status_o[2]));
   cover property (@(negedge sclk_i) disable iff (!reset_n_i) $rose(dout_oe_o));
endmodule : metering_calib_register_bank_checker

bind metering_calib_register_bank metering_calib_register_bank_checker chk_i (.ref_clk_i, .reset_n_i,
   .sclk_i, .cs_n_i, .din_i, .dout_oe_o, .ch2_zero_cross_i, .cycle_mode_i, .status_clear_i,
   .phase_shift_o, .dip_n_o, .irq_n_o, .status_o);

// ==== testbench/host_serial_model.sv ====
`timescale 1ns/1ns
module host_serial_model (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic dout_i,
   input  wire logic dout_oe_i
);
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end
   // ------------------------------------------------------------
   // framed transfer: sclk idles high and runs only inside a frame
   // ------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [4:0] addr, input logic [39:0] wd,
                       input int n, output logic [39:0] rd);
      logic [7:0] cmd;
      cmd = {wr, 2'b00, addr};
      rd  = 40'h0;
      #1 cs_n_o = 1'b0;
      #20;
      for (int i = 0; i < 8 + n; i++) begin
         din_o = (i < 8) ? cmd[7 - i] : (wr ? wd[n + 7 - i] : ~din_o);
         #16;
         // an undriven dout must never pass for data
         if (i >= 8) rd = {rd[38:0], dout_oe_i ? dout_i : 1'bx};
         sclk_o = 1'b0;
         #16 sclk_o = 1'b1;
      end
      #16 cs_n_o = 1'b1;
      din_o = ~din_o;
   endtask : xfer
endmodule : host_serial_model

// ==== testbench/metering_calib_register_bank_bench.sv ====
`timescale 1ns/1ns
`include "metering_consts.svh"
module metering_calib_register_bank_bench;
   import metering_pkg::*;
   localparam logic [7:0] REV = 8'h3c;   // arbitrary value
   logic        ref_clk_i, reset_n_i, power_valid_i, ch2_zero_cross_i, temp_done_i, cycle_mode_i;
   logic [7:0]  ch2_peak_i, temp_value_i, status_clear_i, phase_shift_o, status_o;
   logic [11:0] pulse_den_i;
   power_t      raw_power_i, corrected_power_o;
   logic        sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, energy_pulse_o, dip_n_o, irq_n_o;
   logic [39:0] rd;
   int          bad_count, num_checks, pulses;

   metering_calib_register_bank #(.ZX_TICK_CYCLES(4), .PULSE_SHIFT(0), .SILICON_REV(REV)) DUT (
      .ref_clk_i, .reset_n_i, .sclk_i, .cs_n_i, .din_i, .dout_o, .dout_oe_o, .raw_power_i,
      .power_valid_i, .ch2_zero_cross_i, .ch2_peak_i, .temp_value_i, .temp_done_i, .cycle_mode_i,
      .pulse_den_i, .status_clear_i, .corrected_power_o, .phase_shift_o, .energy_pulse_o, .dip_n_o,
      .irq_n_o, .status_o);
   host_serial_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o),
      .dout_oe_i(dout_oe_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   always @(negedge ref_clk_i) if (energy_pulse_o === 1'b1) pulses++;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task chk(input logic [39:0] got, input logic [39:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc
   task rdr(input logic [4:0] a, input int n, input logic [39:0] exp);
      host.xfer(1'b0, a, 40'h0, n, rd);
      cyc(1);
      chk(rd, exp);
   endtask : rdr
   // a read must trail a write by 4 us or it may return the value from before the write
   task wr(input logic [4:0] a, input int n, input logic [39:0] d);
      host.xfer(1'b1, a, d, n, rd);
      cyc(1000);
   endtask : wr
   task zc(input logic [7:0] pk);
      ch2_peak_i = pk;
      ch2_zero_cross_i = 1'b1;
      cyc(1);
      ch2_zero_cross_i = 1'b0;
      cyc(1);
   endtask : zc
   task smp(input logic [23:0] v);
      raw_power_i = v;
      power_valid_i = 1'b1;
      cyc(1);
      power_valid_i = 1'b0;
      cyc(1);
   endtask : smp
   task clr;
      status_clear_i = 8'hff;
      cyc(1);
      status_clear_i = 8'h00;
      cyc(1);
   endtask : clr
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      rdr(`ADDR_ZX_TIMEOUT, 16, 40'hfff);
      rdr(`ADDR_DIP_CYCLES, 8, 40'hff);
      rdr(`ADDR_IRQ_MASK, 8, 40'h40);
      rdr(`ADDR_HALF_CYCLES, 16, 40'h3fff);
      rdr(`ADDR_PULSE_NUM, 16, 40'h0);
      rdr(`ADDR_REVISION, 8, {32'h0, REV});
      rdr(`ADDR_ONES_COUNT, 8, 40'h4);
      rdr(5'h16, 8, 40'h0);
   endtask : t_reset
   task t_ro;
      temp_value_i = 8'h5a;
      temp_done_i = 1'b1;
      cyc(1);
      temp_done_i = 1'b0;
      wr(`ADDR_ONES_COUNT, 8, 40'h3f);
      rdr(`ADDR_ONES_COUNT, 8, 40'h0);
      wr(`ADDR_TEMPERATURE, 8, 40'hff);
      rdr(`ADDR_TEMPERATURE, 8, 40'h5a);
      rdr(`ADDR_ONES_COUNT, 8, 40'h4);
   endtask : t_ro
   task t_phase;
      logic [7:0] wv [3] = '{8'h80, 8'h7f, 8'he0};
      logic [7:0] ev [3] = '{8'h9e, 8'h5c, 8'he0};
      foreach (wv[i]) begin
         wr(`ADDR_PHASE, 8, {32'h0, wv[i]});
         chk({32'h0, phase_shift_o}, {32'h0, ev[i]});
      end
      rdr(`ADDR_PHASE, 8, 40'he0);
   endtask : t_phase
   task t_dip;
      logic [7:0] pk [5] = '{8'h10, 8'h10, 8'h40, 8'h10, 8'h10};
      wr(`ADDR_DIP_LEVEL, 8, 40'h40);
      wr(`ADDR_DIP_CYCLES, 8, 40'h3);
      foreach (pk[i]) zc(pk[i]);
      chk({39'h0, dip_n_o}, 40'h1);
      zc(8'h10);
      cyc(2);
      chk({39'h0, dip_n_o}, 40'h0);
      chk({39'h0, status_o[3]}, 40'h1);
   endtask : t_dip
   task t_zx;
      wr(`ADDR_ZX_TIMEOUT, 16, 40'h3);
      zc(8'h80);
      clr();
      for (int i = 0; i < 6; i++) begin
         zc(8'h80);
         cyc(4);
      end
      chk({39'h0, status_o[4]}, 40'h0);
      cyc(40);
      chk({39'h0, status_o[4]}, 40'h1);
      chk({39'h0, irq_n_o}, 40'h1);
      wr(`ADDR_IRQ_MASK, 8, 40'h10);
      chk({39'h0, irq_n_o}, 40'h0);
      wr(`ADDR_IRQ_MASK, 8, 40'h0);
      chk({39'h0, irq_n_o}, 40'h1);
   endtask : t_zx
   task t_line;
      cycle_mode_i = 1'b1;
      wr(`ADDR_HALF_CYCLES, 16, 40'h2);
      for (int i = 0; i < 4 && status_o[2] !== 1'b1; i++) zc(8'h80);
      chk({39'h0, status_o[2]}, 40'h1);
      clr();
      pulses = 0;
      for (int i = 0; i < 3; i++) smp(24'h5);
      zc(8'h80);
      chk({39'h0, status_o[2]}, 40'h0);
      zc(8'h80);
      chk({39'h0, status_o[2]}, 40'h1);
      rdr(`ADDR_CYCLE_ENERGY, 40, 40'hf);
      chk(40'(pulses), 40'h1);
      wr(`ADDR_PULSE_NUM, 16, 40'h1);
      pulses = 0;
      for (int i = 0; i < 3; i++) smp(24'h5);
      cyc(4);
      chk(40'(pulses), 40'h3);
   endtask : t_line
   task t_power;
      wr(`ADDR_POWER_GAIN, 16, 40'hf400);
      wr(`ADDR_POWER_OFFSET, 16, 40'h10);
      rdr(`ADDR_POWER_GAIN, 16, 40'h400);
      smp(24'h1000);
      chk({16'h0, corrected_power_o}, 40'h1410);
   endtask : t_power
   task stop_test;
      if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {reset_n_i, power_valid_i, ch2_zero_cross_i, temp_done_i, cycle_mode_i} = 5'h0;
      {ch2_peak_i, temp_value_i, status_clear_i} = 24'h0;
      raw_power_i = 24'h0;
      pulse_den_i = 12'h9;
      cyc(8);
      reset_n_i = 1'b1;
      cyc(4);
      t_reset();
      t_ro();
      t_phase();
      t_dip();
      t_zx();
      t_line();
      t_power();
      stop_test();
   end
   initial begin
      #400000;
      bad_count++;
      stop_test();
   end
endmodule : metering_calib_register_bank_bench
